// >>> design/ddac_params.svh
`ifndef DDAC_PARAMS_SVH
`define DDAC_PARAMS_SVH

// ==========================================================================
// Clock and time base
`define DDAC_CLK_MHZ 100
`define DDAC_TICK_US 100
`define DDAC_TICK_CYC (`DDAC_TICK_US * `DDAC_CLK_MHZ)

// ==========================================================================
// Mechanical timing, each in its own unit, then in time-base ticks
`define DDAC_REV_PERIOD_TENTH_MS 1667
`define DDAC_REV_TICKS (`DDAC_REV_PERIOD_TENTH_MS * 100 / `DDAC_TICK_US)
`define DDAC_INDEX_WIDTH_MS 1
`define DDAC_INDEX_TICKS (`DDAC_INDEX_WIDTH_MS * 1000 / `DDAC_TICK_US)
`define DDAC_HEAD_SETTLE_MS 80
`define DDAC_HEAD_SETTLE_TICKS (`DDAC_HEAD_SETTLE_MS * 1000 / `DDAC_TICK_US)
`define DDAC_STEP_MS 5
`define DDAC_STEP_TICKS (`DDAC_STEP_MS * 1000 / `DDAC_TICK_US)
`define DDAC_CARRIAGE_SETTLE_MS 35
`define DDAC_CARRIAGE_SETTLE_TICKS (`DDAC_CARRIAGE_SETTLE_MS * 1000 / `DDAC_TICK_US)

// ==========================================================================
// Carriage geometry and phase patterns, two adjacent lines per position
`define DDAC_LAST_TRACK 7'h4c
`define DDAC_PH_0 4'h3
`define DDAC_PH_1 4'h6
`define DDAC_PH_2 4'hc
`define DDAC_PH_3 4'h9

// ==========================================================================
// Addressing and configuration entry
`define DDAC_ADDR_LEVEL 8'h01
`define DDAC_ADDR_POS 4'h7
`define DDAC_ADDR_GROUP_BASE 4'h8
`define DDAC_SAT_MAX 3'h4
`define DDAC_OPTION_UNUSED 16'h0000

`endif

// >>> design/ddac_pkg.sv
package ddac_pkg;
    typedef logic [10:0] ddac_ticks_t;
    typedef logic [6:0] ddac_track_t;
    typedef enum logic [1:0] {MEDIA_NONE, MEDIA_ONE_SIDED, MEDIA_TWO_SIDED} ddac_media_e;
    typedef enum logic [1:0] {STEP_HOLD, STEP_IN, STEP_OUT} ddac_step_e;
    typedef enum logic [1:0] {HEAD_IDLE, HEAD_SETTLING, HEAD_READY} ddac_head_e;
endpackage : ddac_pkg

// >>> design/ddac_timer.sv
`include "ddac_params.svh"

module ddac_timer
    import ddac_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire ddac_ticks_t load_val,
    output logic done
);
    ddac_ticks_t count;

    // Reads as expired out of reset so that nothing waits on a timer never started.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            done <= 1'b1;
        end else if (start) begin
            count <= load_val;
            done <= 1'b0;
        end else if (tick && count != '0) begin
            count <= count - 11'h001;
            if (count == 11'h001) begin
                done <= 1'b1;
            end
        end
    end
endmodule : ddac_timer

// >>> design/ddac_drive.sv
// Operation
// - Emit one index pulse per revolution, every 166.7 ms, while media spins.
// - Assert sides sense for two-sided media; type is classified from it.
// - Data valid only 80 ms after head load; no transfer before that.
// - Two-hex-digit address: group digit, then position digit fixed at 7.
// - Configuration entry: level 01, address, unit type, two unused options.
`include "ddac_params.svh"

module ddac_drive
    import ddac_pkg::*;
#(
    parameter int TICK_CYCLES = `DDAC_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic media_present,
    input wire logic two_sided_sense,
    input wire logic head_load_req,
    input wire logic [3:0] phase_lines,
    input wire logic [2:0] sat_select,
    input wire logic addr_strobe,
    input wire logic [7:0] addr_in,
    input wire logic step_fault_clr,
    output logic index_pulse,
    output ddac_media_e media_type,
    output logic head_solenoid,
    output logic data_valid,
    output ddac_track_t track,
    output logic track0,
    output logic carriage_settled,
    output logic step_fault,
    output logic unit_selected,
    output logic [7:0] unit_phys_address,
    output logic [7:0] addressing_level,
    output logic [15:0] unit_type_code,
    output logic [15:0] option_params_a,
    output logic [15:0] option_params_b
);
    // Arbitrary neutral unit type value.
    localparam logic [15:0] UNIT_TYPE_VALUE = 16'h0a5c;
    localparam int HEAD_TICKS = `DDAC_HEAD_SETTLE_TICKS;
    localparam int STEP_TICKS = `DDAC_STEP_TICKS;

    // ======================================================================
    // Time base
    logic [13:0] div_count;
    logic tick;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_count <= '0;
            tick <= 1'b0;
        end else if (div_count == 14'(TICK_CYCLES - 1)) begin
            div_count <= '0;
            tick <= 1'b1;
        end else begin
            div_count <= div_count + 14'h0001;
            tick <= 1'b0;
        end
    end

    // ======================================================================
    // Revolution and media sensing
    ddac_ticks_t rev_count;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rev_count <= '0;
            index_pulse <= 1'b0;
        end else if (!media_present) begin
            rev_count <= '0;
            index_pulse <= 1'b0;
        end else begin
            if (tick) begin
                rev_count <= (rev_count == 11'(`DDAC_REV_TICKS - 1)) ? 11'h000 : rev_count + 11'h001;
            end
            index_pulse <= (rev_count < 11'(`DDAC_INDEX_TICKS));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            media_type <= MEDIA_NONE;
        end else if (!media_present) begin
            media_type <= MEDIA_NONE;
        end else begin
            media_type <= two_sided_sense ? MEDIA_TWO_SIDED : MEDIA_ONE_SIDED;
        end
    end

    // ======================================================================
    // Head load and data valid
    ddac_head_e head_state;
    ddac_head_e next_head_state;
    logic head_start;
    logic head_done;

    always_comb begin
        next_head_state = head_state;
        head_start = 1'b0;
        case (head_state)
            HEAD_IDLE: begin
                if (head_load_req) begin
                    next_head_state = HEAD_SETTLING;
                    head_start = 1'b1;
                end
            end
            HEAD_SETTLING: begin
                if (!head_load_req) begin
                    next_head_state = HEAD_IDLE;
                end else if (head_done) begin
                    next_head_state = HEAD_READY;
                end
            end
            HEAD_READY: begin
                if (!head_load_req) begin
                    next_head_state = HEAD_IDLE;
                end
            end
            default: begin
                next_head_state = HEAD_IDLE;
            end
        endcase
    end

    ddac_timer u_head_timer (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .start(head_start),
        .load_val(11'(HEAD_TICKS)),
        .done(head_done)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head_state <= HEAD_IDLE;
            head_solenoid <= 1'b0;
        end else begin
            head_state <= next_head_state;
            head_solenoid <= (next_head_state != HEAD_IDLE);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_valid <= 1'b0;
        end else begin
            data_valid <= (head_state == HEAD_READY) && head_load_req && media_present;
        end
    end

    // ======================================================================
    // Stepper decode and carriage position
    logic [3:0] phase_q;
    ddac_step_e step_dir;
    ddac_track_t next_track;
    logic step_done;
    logic settle_done;
    logic any_step;

    function automatic logic [3:0] ddac_ph_next(input logic [3:0] ph);
        case (ph)
            `DDAC_PH_0: ddac_ph_next = `DDAC_PH_1;
            `DDAC_PH_1: ddac_ph_next = `DDAC_PH_2;
            `DDAC_PH_2: ddac_ph_next = `DDAC_PH_3;
            `DDAC_PH_3: ddac_ph_next = `DDAC_PH_0;
            default: ddac_ph_next = 4'hf;
        endcase
    endfunction : ddac_ph_next

    always_comb begin
        if (phase_lines != phase_q && phase_lines == ddac_ph_next(phase_q)) begin
            step_dir = STEP_IN;
        end else if (phase_lines != phase_q && phase_q == ddac_ph_next(phase_lines)) begin
            step_dir = STEP_OUT;
        end else begin
            step_dir = STEP_HOLD;
        end
    end

    assign any_step = (step_dir != STEP_HOLD);

    always_comb begin
        next_track = track;
        if (step_dir == STEP_IN && track != `DDAC_LAST_TRACK) begin
            next_track = track + 7'h01;
        end else if (step_dir == STEP_OUT && track != 7'h00) begin
            next_track = track - 7'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= `DDAC_PH_0;
            track <= '0;
            track0 <= 1'b1;
        end else begin
            phase_q <= phase_lines;
            track <= next_track;
            track0 <= (next_track == 7'h00);
        end
    end

    ddac_timer u_step_timer (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .start(any_step),
        .load_val(11'(STEP_TICKS)),
        .done(step_done)
    );

    ddac_timer u_settle_timer (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .start(any_step),
        .load_val(11'(`DDAC_CARRIAGE_SETTLE_TICKS)),
        .done(settle_done)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carriage_settled <= 1'b1;
        end else begin
            carriage_settled <= settle_done && !any_step;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_fault <= 1'b0;
        end else if (any_step && !step_done) begin
            step_fault <= 1'b1;
        end else if (step_fault_clr) begin
            step_fault <= 1'b0;
        end
    end

    // ======================================================================
    // Addressing and configuration entry
    logic cfg_taken;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_taken <= 1'b0;
            unit_phys_address <= {`DDAC_ADDR_GROUP_BASE, `DDAC_ADDR_POS};
            addressing_level <= `DDAC_ADDR_LEVEL;
            unit_type_code <= UNIT_TYPE_VALUE;
            option_params_a <= `DDAC_OPTION_UNUSED;
            option_params_b <= `DDAC_OPTION_UNUSED;
        end else if (!cfg_taken) begin
            cfg_taken <= 1'b1;
            if (sat_select <= `DDAC_SAT_MAX) begin
                unit_phys_address <= {`DDAC_ADDR_GROUP_BASE + {1'b0, sat_select}, `DDAC_ADDR_POS};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_selected <= 1'b0;
        end else begin
            unit_selected <= addr_strobe && cfg_taken && (addr_in == unit_phys_address);
        end
    end

    // ======================================================================
    // Checks
    logic [10:0] head_age;
    logic [10:0] step_age;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head_age <= '0;
            step_age <= 11'h7ff;
        end else begin
            if (!head_solenoid) begin
                head_age <= '0;
            end else if (tick && head_age != 11'h7ff) begin
                head_age <= head_age + 11'h001;
            end
            if (any_step) begin
                step_age <= '0;
            end else if (tick && step_age != 11'h7ff) begin
                step_age <= step_age + 11'h001;
            end
        end
    end

    sequence s_step_in;
        step_dir == STEP_IN && track != `DDAC_LAST_TRACK;
    endsequence

    sequence s_step_out_home;
        step_dir == STEP_OUT && track == 7'h00;
    endsequence

    sequence s_head_up;
        $rose(head_solenoid);
    endsequence

    a_index_no_media: assert property (@(posedge clk) disable iff (rst)
        !media_present |=> !index_pulse) else $error("index pulse without media");
    a_media_two_side: assert property (@(posedge clk) disable iff (rst)
        media_present && two_sided_sense |=> media_type == MEDIA_TWO_SIDED) else $error("wrong media type");
    a_head_follows: assert property (@(posedge clk) disable iff (rst)
        head_load_req |=> head_solenoid) else $error("solenoid not energised");
    a_valid_not_early: assert property (@(posedge clk) disable iff (rst)
        data_valid |-> head_solenoid && head_age >= 11'(HEAD_TICKS - 1)) else $error("data valid too early");
    a_valid_gap: assert property (@(posedge clk) disable iff (rst)
        s_head_up |-> !data_valid [*8]) else $error("data valid at head load");
    a_step_in_move: assert property (@(posedge clk) disable iff (rst)
        s_step_in |=> track == $past(track) + 7'h01) else $error("step in did not advance");
    a_step_too_fast: assert property (@(posedge clk) disable iff (rst)
        any_step && step_age < 11'(STEP_TICKS - 1) |=> step_fault) else $error("fast step not flagged");
    a_settle_busy: assert property (@(posedge clk) disable iff (rst)
        any_step |=> !carriage_settled [*2]) else $error("settled right after step");
    a_detent_hold: assert property (@(posedge clk) disable iff (rst)
        phase_lines == phase_q |=> $stable(track)) else $error("track moved in detent");
    a_head_drop: assert property (@(posedge clk) disable iff (rst)
        !head_load_req |=> !head_solenoid && !data_valid) else $error("head not dropped");
    a_home_stop: assert property (@(posedge clk) disable iff (rst)
        s_step_out_home |=> track == 7'h00 && track0) else $error("moved past track zero");
    a_addr_select: assert property (@(posedge clk) disable iff (rst)
        addr_strobe && cfg_taken && addr_in == unit_phys_address |=> unit_selected) else $error("address missed");
    a_addr_form: assert property (@(posedge clk) disable iff (rst)
        unit_phys_address[3:0] == `DDAC_ADDR_POS && unit_phys_address[7:4] >= 4'h8
        && unit_phys_address[7:4] <= 4'hc) else $error("bad unit address");
    a_cfg_level: assert property (@(posedge clk) disable iff (rst)
        addressing_level == `DDAC_ADDR_LEVEL && option_params_a == 16'h0000) else $error("bad config entry");
endmodule : ddac_drive

// >>> tb/ddac_adapter_model.sv
`include "ddac_params.svh"

module ddac_adapter_model #(
    parameter int TICK_CYCLES = 2
) (
    input wire logic clk,
    output logic head_load_req,
    output logic [3:0] phase_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    // One tick and two cycles of margin, because the tick phase is unknown to the adapter.
    localparam int GAP = 51 * TICK_CYCLES + 2;
    logic [3:0] seq [4] = '{`DDAC_PH_0, `DDAC_PH_1, `DDAC_PH_2, `DDAC_PH_3};
    int pos = 0;

    initial begin
        head_load_req = 1'b0;
        phase_lines = `DDAC_PH_0;
    end

    task automatic head(input logic on);
        @(negedge clk);
        head_load_req = on;
    endtask : head

    task automatic step(input logic inward);
        @(negedge clk);
        pos = inward ? (pos + 1) % 4 : (pos + 3) % 4;
        phase_lines = seq[pos];
    endtask : step

    task automatic seek(input int n, input logic inward);
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (GAP) @(negedge clk);
            step(inward);
        end
    endtask : seek

    task automatic recal();
        repeat (GAP) @(negedge clk);
        seek(80, 1'b0);
        repeat (351 * TICK_CYCLES + 2) @(negedge clk);
    endtask : recal
endmodule : ddac_adapter_model

// >>> tb/tb_top.sv
`include "ddac_params.svh"

module tb_top
    import ddac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 2;
    logic clk;
    logic rst;
    logic media_present;
    logic two_sided_sense;
    logic head_load_req;
    logic [3:0] phase_lines;
    logic [2:0] sat_select;
    logic addr_strobe;
    logic [7:0] addr_in;
    logic step_fault_clr;
    logic index_pulse, head_solenoid, data_valid, track0, carriage_settled, step_fault, unit_selected;
    ddac_media_e media_type;
    ddac_track_t track;
    logic [7:0] unit_phys_address, addressing_level;
    logic [15:0] unit_type_code, option_params_a, option_params_b;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rs = 32'h42;
    logic [15:0] exp_q[$];
    logic [15:0] seen_q[$];
    string name_q[$];

    ddac_drive #(.TICK_CYCLES(TC)) ddac_drive_i (.clk(clk), .rst(rst), .media_present(media_present),
        .two_sided_sense(two_sided_sense), .head_load_req(head_load_req), .phase_lines(phase_lines),
        .sat_select(sat_select), .addr_strobe(addr_strobe), .addr_in(addr_in),
        .step_fault_clr(step_fault_clr), .index_pulse(index_pulse), .media_type(media_type),
        .head_solenoid(head_solenoid), .data_valid(data_valid), .track(track), .track0(track0),
        .carriage_settled(carriage_settled), .step_fault(step_fault), .unit_selected(unit_selected),
        .unit_phys_address(unit_phys_address), .addressing_level(addressing_level),
        .unit_type_code(unit_type_code), .option_params_a(option_params_a),
        .option_params_b(option_params_b));

    ddac_adapter_model #(.TICK_CYCLES(TC)) ddac_adapter_model_i (.clk(clk),
        .head_load_req(head_load_req), .phase_lines(phase_lines));

    always #5 clk = ~clk;

    // ==========================================
    // Scoreboard and closing
    task automatic note(input string nm, input logic [15:0] ev, input logic [15:0] gv);
        name_q.push_back(nm);
        exp_q.push_back(ev);
        seen_q.push_back(gv);
    endtask : note

    always @(posedge clk) begin
        while (seen_q.size() > 0 && exp_q.size() > 0) begin
            checks_done++;
            if (seen_q[0] !== exp_q[0]) begin
                errors++;
                $display("Error %s expected %h seen %h", name_q[0], exp_q[0], seen_q[0]);
            end
            void'(name_q.pop_front());
            void'(exp_q.pop_front());
            void'(seen_q.pop_front());
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // The whole sequence needs about 20000 cycles, so the ceiling at 60000 cycles lies well above a normal run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    function automatic logic sel(input int which);
        case (which)
            0: return data_valid;
            1: return carriage_settled;
            2: return index_pulse;
            default: return !index_pulse;
        endcase
    endfunction : sel

    task automatic wait_for(input int which, output int n);
        n = 0;
        while (sel(which) !== 1'b1 && n < 9000) begin
            tick(1);
            n++;
        end
    endtask : wait_for

    task automatic do_reset(input logic [2:0] s);
        @(negedge clk);
        rst = 1'b1;
        sat_select = s;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
    endtask : do_reset

    // Looks at two cycles after the strobe, so either register depth is accepted.
    task automatic probe(input logic [7:0] a, output logic hit);
        @(negedge clk);
        addr_strobe = 1'b1;
        addr_in = a;
        @(negedge clk);
        addr_strobe = 1'b0;
        hit = unit_selected;
        @(negedge clk);
        hit = hit | unit_selected;
    endtask : probe

    // ==========================================
    // Main sequence
    initial begin
        logic hit;
        logic [7:0] ea;
        logic [31:0] r;
        int n, t0, k;
        clk = 1'b0;
        rst = 1'b1;
        media_present = 1'b0;
        two_sided_sense = 1'b0;
        sat_select = 3'h0;
        addr_strobe = 1'b0;
        addr_in = 8'h00;
        step_fault_clr = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        note("addressing_level", 16'h1, addressing_level);
        note("option_params", 16'h0, option_params_a | option_params_b);
        note("track0", 16'h1, track0);
        for (int s = 0; s < 6; s++) begin
            do_reset(s[2:0]);
            ea = (s >= 1 && s <= 4) ? {4'h8 + s[3:0], 4'h7} : 8'h87;
            note("unit_phys_address", ea, unit_phys_address);
            probe(ea, hit);
            note("selected", 16'h1, hit);
            r = rnd();
            probe(ea ^ (r[7:0] | 8'h01), hit);
            note("not_selected", 16'h0, hit);
        end
        media_present = 1'b1;
        tick(2);
        note("media_type", MEDIA_ONE_SIDED, media_type);
        @(negedge clk);
        two_sided_sense = 1'b1;
        tick(2);
        note("media_type", MEDIA_TWO_SIDED, media_type);
        // The first pulse starts with the media, so measure from a clean rising edge.
        wait_for(3, n);
        wait_for(2, n);
        t0 = cycles;
        wait_for(3, n);
        note("index_width", 16'(10 * TC), 16'(cycles - t0));
        wait_for(2, n);
        note("index_period", 16'(1667 * TC), 16'(cycles - t0));
        ddac_adapter_model_i.head(1'b1);
        tick(2);
        note("head_solenoid", 16'h1, head_solenoid);
        wait_for(0, n);
        note("head_settle", 16'h1, n >= 800 * TC - 2 && n <= 801 * TC + 3);
        ddac_adapter_model_i.head(1'b0);
        tick(2);
        note("head_off", 16'h0, {head_solenoid, data_valid});
        ddac_adapter_model_i.head(1'b1);
        tick(100);
        ddac_adapter_model_i.head(1'b0);
        ddac_adapter_model_i.head(1'b1);
        tick(2);
        wait_for(0, n);
        note("head_restart", 16'h1, n >= 800 * TC - 2 && n <= 801 * TC + 3);
        @(negedge clk);
        media_present = 1'b0;
        tick(2);
        note("media_lost", {14'h0, MEDIA_NONE}, {data_valid, 13'h0, media_type});
        note("index_gone", 16'h0, index_pulse);
        ddac_adapter_model_i.head(1'b0);
        r = rnd();
        k = 1 + int'(r[1:0]);
        ddac_adapter_model_i.seek(k, 1'b1);
        tick(2);
        note("settling", 16'h0, carriage_settled);
        note("track", k[15:0], track);
        wait_for(1, n);
        note("carriage_settle", 16'h1, n >= 350 * TC - 4 && n <= 351 * TC + 3);
        note("step_fault", 16'h0, step_fault);
        tick(200);
        note("detent_track", k[15:0], track);
        ddac_adapter_model_i.step(1'b1);
        tick(10);
        ddac_adapter_model_i.step(1'b1);
        tick(2);
        note("step_fault", 16'h1, step_fault);
        @(negedge clk);
        step_fault_clr = 1'b1;
        @(negedge clk);
        step_fault_clr = 1'b0;
        tick(1);
        note("step_fault_clr", 16'h0, step_fault);
        ddac_adapter_model_i.recal();
        note("recal_track", 16'h1, {track, track0});
        tick(2);
        report_and_stop();
    end
endmodule : tb_top
